// >>> hdl/exec_pkg.sv
`default_nettype none

package exec_pkg;

  // Operations that the decoder hands to this block.
  typedef enum logic [2:0] {
    no_op                 = 3'b000,
    halt_op               = 3'b001,
    return_op             = 3'b010,
    rotate_right_carry_op = 3'b011,
    literal_minus_acc_op  = 3'b100,
    file_minus_acc_op     = 3'b101
  } op_type;

  // Execution modes.
  typedef enum logic [1:0] {
    mode_run    = 2'b00,
    mode_flush  = 2'b01,
    mode_halted = 2'b10
  } mode_type;

  // Widths of the core paths.
  localparam int unsigned PC_W   = 13;
  localparam int unsigned FILE_W = 7;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFFSET    = 8'h00;
  localparam logic [7:0] STATUS_OFFSET  = 8'h04;
  localparam logic [7:0] ACC_OFFSET     = 8'h08;
  localparam logic [7:0] RETIRED_OFFSET = 8'h0C;

  // Field positions.
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_RESUME_BIT = 1;
  localparam int unsigned STAT_CARRY_BIT  = 0;
  localparam int unsigned STAT_NIBBLE_BIT = 1;
  localparam int unsigned STAT_ZERO_BIT   = 2;
  localparam int unsigned STAT_PD_BIT     = 3;
  localparam int unsigned STAT_EXPIRY_BIT = 4;
  localparam int unsigned STAT_HALTED_BIT = 5;

  // Values after reset.
  localparam logic [7:0]  ACC_RESET       = 8'h00;
  localparam logic        ENABLE_RESET    = 1'b1;
  localparam logic        STATUS_N_RESET  = 1'b1;
  localparam logic [15:0] RETIRED_RESET   = 16'h0000;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

`default_nettype wire

// >>> hdl/alu_if.sv
`timescale 1ns/10ps
`default_nettype none

// Operands and results between the sequencer and the arithmetic unit.
interface alu_if;
  exec_pkg::op_type op;
  logic [7:0]       operand;
  logic [7:0]       acc;
  logic             carry_in;
  logic [7:0]       result;
  logic             carry_out;
  logic             nib_out;
  logic             zero_out;

  modport calc (
    input  op, operand, acc, carry_in,
    output result, carry_out, nib_out, zero_out
  );
  modport user (
    output op, operand, acc, carry_in,
    input  result, carry_out, nib_out, zero_out
  );
endinterface

`default_nettype wire

// >>> hdl/exec_alu.sv
`timescale 1ns/10ps
`default_nettype none

module exec_alu (
  // Operand and result bundle.
  alu_if.calc p
);

  logic [8:0] diff;
  logic [4:0] low;

  // Subtraction adds the inverted accumulator plus one, so carries are not-borrows.
  assign diff = {1'b0, p.operand} + {1'b0, ~p.acc} + 9'h001;
  assign low  = {1'b0, p.operand[3:0]} + {1'b0, ~p.acc[3:0]} + 5'h01;

  // Rotation passes the old carry into bit 7; everything else takes the difference.
  always_comb begin
    if (p.op == exec_pkg::rotate_right_carry_op) begin
      p.result    = {p.carry_in, p.operand[7:1]};
      p.carry_out = p.operand[0];
    end else begin
      p.result    = diff[7:0];
      p.carry_out = diff[8];
    end
    p.nib_out  = low[4];
    p.zero_out = (diff[7:0] == 8'h00);
  end

endmodule

`default_nettype wire

// >>> hdl/cpu_exec_sleep_ret_rot_sub.sv
// Operation
// RULE1: Halt clears watchdog counter and prescaler.
// RULE2: Halt sets expiry bit, clears powerdown bit.
// RULE3: Halt stops oscillator; no further instructions.
// RULE4: Return pops stack into PC, flags unchanged.
// RULE5: Return takes two cycles, discarding fetched word.
// RULE6: Rotate right through carry; only carry changes.
// RULE7: Rotate destination zero accumulator, one file.
// RULE8: Literal minus accumulator into accumulator.
// RULE9: File minus accumulator, two's complement.
// RULE10: File subtract destination zero accumulator, one file.
// RULE11: Subtracts set carry, nibble borrow, zero.
// RULE12: Rotate and file subtract: one cycle.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module cpu_exec_sleep_ret_rot_sub (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // Instruction issue.
  input  wire logic                     issue_valid,
  input  wire exec_pkg::op_type         issue_op,
  input  wire logic [6:0]               issue_file_addr,
  input  wire logic                     issue_dest,
  input  wire logic [7:0]               issue_literal,
  input  wire logic [7:0]               issue_file_data,
  output logic                          issue_ready,
  // Core state.
  output logic [7:0]                    acc_out,
  output logic                          carry_flag,
  output logic                          nibble_borrow_flag,
  output logic                          zero_flag,
  output logic                          expiry_status_bit,
  output logic                          powerdown_status_bit,
  // File register write port.
  output logic                          file_wr_en,
  output logic [6:0]                    file_wr_addr,
  output logic [7:0]                    file_wr_data,
  // Return stack and program counter.
  input  wire logic [12:0]              stack_top,
  output logic                          stack_pop,
  output logic                          pc_load,
  output logic [12:0]                   pc_value,
  output logic                          flush_fetch,
  // Watchdog and oscillator.
  output logic                          watchdog_counter_clear,
  output logic                          watchdog_prescaler_clear,
  output logic                          osc_stop,
  // AXI4-Lite slave.
  input  wire logic [7:0]               awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [7:0]               araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    exec_pkg::mode_type mode;
    logic [7:0]         acc;
    logic               carry;
    logic               nib;
    logic               zero;
    logic               expiry;
    logic               pd;
    logic               file_we;
    logic [6:0]         file_waddr;
    logic [7:0]         file_wdata;
    logic               pc_load;
    logic               pop;
    logic [12:0]        pc_value;
    logic               flush;
    logic               wdt_clr;
    logic               enable;
    logic [15:0]        retired;
    logic               aw_got;
    logic               w_got;
    logic [7:0]         waddr;
    logic [31:0]        wword;
    logic [3:0]         wmask;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
  } state_type;
  state_type st_r;
  state_type st_nxt;
  logic      fire;
  alu_if     alu ();
  // Decodes a register offset to whether it is mapped.
  function automatic logic mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a == exec_pkg::CTRL_OFFSET) begin
      hit = 1'b1;
    end else if (a == exec_pkg::STATUS_OFFSET) begin
      hit = 1'b1;
    end else if (a == exec_pkg::ACC_OFFSET) begin
      hit = 1'b1;
    end else if (a == exec_pkg::RETIRED_OFFSET) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic unit.
  // The literal is the operand only for the literal subtract.
  assign alu.op       = issue_op;
  assign alu.operand  = (issue_op == exec_pkg::literal_minus_acc_op) ?
                        issue_literal : issue_file_data;
  assign alu.acc      = st_r.acc;
  assign alu.carry_in = st_r.carry;

  exec_alu u_alu (
    .p (alu.calc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes.
  // A halted core or a flush cycle refuses issue; software may also gate it.
  assign issue_ready = (st_r.mode == exec_pkg::mode_run) && st_r.enable;
  assign fire        = issue_valid && issue_ready;
  assign awready     = !st_r.aw_got && !st_r.bvalid;
  assign wready      = !st_r.w_got && !st_r.bvalid;
  assign arready     = !st_r.rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  // One pass computes the whole next state; pulses fall back to zero each cycle.
  always_comb begin
    st_nxt         = st_r;
    st_nxt.file_we = 1'b0;
    st_nxt.pc_load = 1'b0;
    st_nxt.pop     = 1'b0;
    st_nxt.flush   = 1'b0;
    st_nxt.wdt_clr = 1'b0;

    // The discard cycle lasts exactly one cycle.
    if (st_r.mode == exec_pkg::mode_flush) begin
      st_nxt.mode = exec_pkg::mode_run; // RULE5
    end

    if (fire) begin
      st_nxt.retired = st_r.retired + 16'h0001;
      case (issue_op)
        exec_pkg::halt_op: begin
          st_nxt.wdt_clr = 1'b1; // RULE1
          st_nxt.expiry  = 1'b1; // RULE2
          st_nxt.pd      = 1'b0; // RULE2
          st_nxt.mode    = exec_pkg::mode_halted; // RULE3
        end
        exec_pkg::return_op: begin
          st_nxt.pc_load  = 1'b1; // RULE4
          st_nxt.pop      = 1'b1; // RULE4
          st_nxt.pc_value = stack_top; // RULE4
          st_nxt.flush    = 1'b1; // RULE5
          st_nxt.mode     = exec_pkg::mode_flush; // RULE5
        end
        exec_pkg::rotate_right_carry_op: begin
          st_nxt.carry = alu.carry_out; // RULE6
          if (issue_dest) begin
            st_nxt.file_we    = 1'b1; // RULE7
            st_nxt.file_waddr = issue_file_addr; // RULE12
            st_nxt.file_wdata = alu.result;
          end else begin
            st_nxt.acc = alu.result; // RULE7
          end
        end
        exec_pkg::literal_minus_acc_op: begin
          st_nxt.acc   = alu.result; // RULE8
          st_nxt.carry = alu.carry_out; // RULE11
          st_nxt.nib   = alu.nib_out; // RULE11
          st_nxt.zero  = alu.zero_out; // RULE11
        end
        exec_pkg::file_minus_acc_op: begin
          st_nxt.carry = alu.carry_out; // RULE11
          st_nxt.nib   = alu.nib_out; // RULE11
          st_nxt.zero  = alu.zero_out; // RULE11
          if (issue_dest) begin
            st_nxt.file_we    = 1'b1; // RULE10
            st_nxt.file_waddr = issue_file_addr; // RULE12
            st_nxt.file_wdata = alu.result; // RULE9
          end else begin
            st_nxt.acc = alu.result; // RULE10
          end
        end
        default: begin
        end
      endcase
    end

    // Address and data are caught in either order.
    if (awvalid && awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.waddr  = awaddr;
    end
    if (wvalid && wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wword = wdata;
      st_nxt.wmask = wstrb;
    end

    // A write completes one cycle after both halves are held.
    if (st_r.aw_got && st_r.w_got) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = mapped(st_r.waddr) ? exec_pkg::RESP_OKAY :
                      exec_pkg::RESP_SLVERR;
      if (st_r.waddr == exec_pkg::CTRL_OFFSET && st_r.wmask[0]) begin
        st_nxt.enable = st_r.wword[exec_pkg::CTRL_ENABLE_BIT];
        // Resume is the only way out of halt here; wake logic sits outside.
        if (st_r.wword[exec_pkg::CTRL_RESUME_BIT] &&
            st_r.mode == exec_pkg::mode_halted) begin
          st_nxt.mode = exec_pkg::mode_run;
        end
      end
    end else if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken.
    if (arvalid && arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = mapped(araddr) ? exec_pkg::RESP_OKAY :
                      exec_pkg::RESP_SLVERR;
      st_nxt.rdata  = 32'h0000_0000;
      if (araddr == exec_pkg::CTRL_OFFSET) begin
        st_nxt.rdata[exec_pkg::CTRL_ENABLE_BIT] = st_r.enable;
      end else if (araddr == exec_pkg::STATUS_OFFSET) begin
        st_nxt.rdata[exec_pkg::STAT_CARRY_BIT]  = st_r.carry;
        st_nxt.rdata[exec_pkg::STAT_NIBBLE_BIT] = st_r.nib;
        st_nxt.rdata[exec_pkg::STAT_ZERO_BIT]   = st_r.zero;
        st_nxt.rdata[exec_pkg::STAT_PD_BIT]     = st_r.pd;
        st_nxt.rdata[exec_pkg::STAT_EXPIRY_BIT] = st_r.expiry;
        st_nxt.rdata[exec_pkg::STAT_HALTED_BIT] =
          (st_r.mode == exec_pkg::mode_halted);
      end else if (araddr == exec_pkg::ACC_OFFSET) begin
        st_nxt.rdata[7:0] = st_r.acc;
      end else if (araddr == exec_pkg::RETIRED_OFFSET) begin
        st_nxt.rdata[15:0] = st_r.retired;
      end
    end else if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  // Active-low status bits power up high, as after a cold start.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r         <= '0;
      st_r.mode    <= exec_pkg::mode_run;
      st_r.acc     <= exec_pkg::ACC_RESET;
      st_r.expiry  <= exec_pkg::STATUS_N_RESET;
      st_r.pd      <= exec_pkg::STATUS_N_RESET;
      st_r.enable  <= exec_pkg::ENABLE_RESET;
      st_r.retired <= exec_pkg::RETIRED_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  // Both watchdog clears share one pulse so they can never drift apart.
  assign acc_out                  = st_r.acc;
  assign carry_flag               = st_r.carry;
  assign nibble_borrow_flag       = st_r.nib;
  assign zero_flag                = st_r.zero;
  assign expiry_status_bit        = st_r.expiry;
  assign powerdown_status_bit     = st_r.pd;
  assign file_wr_en               = st_r.file_we;
  assign file_wr_addr             = st_r.file_waddr;
  assign file_wr_data             = st_r.file_wdata;
  assign stack_pop                = st_r.pop;
  assign pc_load                  = st_r.pc_load;
  assign pc_value                 = st_r.pc_value;
  assign flush_fetch              = st_r.flush;
  assign watchdog_counter_clear   = st_r.wdt_clr; // RULE1
  assign watchdog_prescaler_clear = st_r.wdt_clr; // RULE1
  assign osc_stop                 = (st_r.mode == exec_pkg::mode_halted); // RULE3
  assign bvalid                   = st_r.bvalid;
  assign bresp                    = st_r.bresp;
  assign rvalid                   = st_r.rvalid;
  assign rresp                    = st_r.rresp;
  assign rdata                    = st_r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  halt_wdt_clear_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
    fire && issue_op == exec_pkg::halt_op |=>
      watchdog_counter_clear && watchdog_prescaler_clear ##1
      !watchdog_counter_clear)
    else $error("halt did not clear the watchdog for one cycle");
  halt_status_bits_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
    fire && issue_op == exec_pkg::halt_op |=>
      expiry_status_bit && !powerdown_status_bit)
    else $error("halt left wrong status bits");
  halt_stops_core_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
    fire && issue_op == exec_pkg::halt_op |=>
      (osc_stop && !issue_ready)[*3])
    else $error("core ran on after halt");
  return_pc_load_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
    fire && issue_op == exec_pkg::return_op |=>
      pc_load && stack_pop && pc_value == $past(stack_top) &&
      $stable({carry_flag, nibble_borrow_flag, zero_flag}))
    else $error("return did not load the stack top");
  return_two_cycle_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
    fire && issue_op == exec_pkg::return_op |=>
      flush_fetch && !issue_ready ##1 !flush_fetch)
    else $error("return did not take a discard cycle");
  rotate_carry_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
    fire && issue_op == exec_pkg::rotate_right_carry_op |=>
      carry_flag == $past(issue_file_data[0]) &&
      $stable({nibble_borrow_flag, zero_flag}))
    else $error("rotate moved the wrong carry");
  rotate_dest_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
    fire && issue_op == exec_pkg::rotate_right_carry_op |=>
      (file_wr_en ? file_wr_data : acc_out) ==
      {$past(carry_flag), $past(issue_file_data[7:1])} &&
      file_wr_en == $past(issue_dest))
    else $error("rotate result misplaced");
  literal_sub_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE8
    fire && issue_op == exec_pkg::literal_minus_acc_op |=>
      acc_out == 8'($past(issue_literal) - $past(acc_out)) && !file_wr_en)
    else $error("literal subtract wrong");
  file_sub_dest_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
    fire && issue_op == exec_pkg::file_minus_acc_op && issue_dest |=>
      file_wr_en && file_wr_addr == $past(issue_file_addr) &&
      file_wr_data == 8'($past(issue_file_data) - $past(acc_out))) // RULE9
    else $error("file subtract write-back wrong");
  sub_flags_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE11
    fire && (issue_op == exec_pkg::file_minus_acc_op ||
             issue_op == exec_pkg::literal_minus_acc_op) |=>
      carry_flag == ($past(alu.operand) >= $past(acc_out)) &&
      nibble_borrow_flag == ($past(alu.operand[3:0]) >= $past(acc_out[3:0])) &&
      zero_flag == ($past(alu.operand) == $past(acc_out)))
    else $error("subtract flags wrong");
  single_cycle_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
    fire && (issue_op == exec_pkg::rotate_right_carry_op ||
             issue_op == exec_pkg::file_minus_acc_op) |=>
      st_r.mode == exec_pkg::mode_run && !flush_fetch)
    else $error("one-cycle operation stalled");

endmodule

`default_nettype wire

// >>> tb/cpu_exec_sleep_ret_rot_sub_test.sv
`timescale 1ns/10ps
`default_nettype none

module cpu_exec_sleep_ret_rot_sub_test;
  logic             clk, reset_n, issue_valid, issue_dest, issue_ready;
  exec_pkg::op_type issue_op;
  logic [6:0]       issue_file_addr, file_wr_addr;
  logic [7:0]       issue_literal, issue_file_data, acc_out, file_wr_data, awaddr, araddr;
  logic             carry_flag, nibble_borrow_flag, zero_flag, expiry_status_bit;
  logic             powerdown_status_bit, file_wr_en, stack_pop, pc_load, flush_fetch;
  logic             watchdog_counter_clear, watchdog_prescaler_clear, osc_stop;
  logic [12:0]      stack_top, pc_value;
  logic             awvalid, awready, wvalid, wready, bvalid, bready;
  logic             arvalid, arready, rvalid, rready;
  logic [31:0]      wdata, rdata, rnd;
  logic [3:0]       wstrb;
  logic [1:0]       bresp, rresp;
  logic [48:0]      exp_q[$];
  logic [33:0]      aq[$];
  logic             m_c, m_dc, m_z, m_pd, m_to, pend;
  logic [7:0]       m_acc;
  int               num_errors, samples_checked, retired, cycles;
  exec_pkg::op_type ops[4];

  cpu_exec_sleep_ret_rot_sub dut (.clk, .reset_n, .issue_valid, .issue_op, .issue_file_addr,
    .issue_dest, .issue_literal, .issue_file_data, .issue_ready, .acc_out, .carry_flag,
    .nibble_borrow_flag, .zero_flag, .expiry_status_bit, .powerdown_status_bit, .file_wr_en,
    .file_wr_addr, .file_wr_data, .stack_top, .stack_pop, .pc_load, .pc_value, .flush_fetch,
    .watchdog_counter_clear, .watchdog_prescaler_clear, .osc_stop, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);

  // Outputs one cycle after an accepted issue; stale address fields are masked off.
  wire logic [48:0] snap = {acc_out, carry_flag, nibble_borrow_flag, zero_flag, file_wr_en,
    file_wr_en ? file_wr_addr : 7'h00, file_wr_en ? file_wr_data : 8'h00, pc_load, stack_pop,
    pc_load ? pc_value : 13'h0000, flush_fetch, watchdog_counter_clear,
    watchdog_prescaler_clear, expiry_status_bit, powerdown_status_bit, osc_stop, issue_ready};

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 100 ns period.
  always #50 clk = ~clk;

  task automatic fail(input string s);
    $display("mismatch at %0t: %s", $time, s);
    num_errors++;
  endtask

  task automatic summarize();
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Advances the shift register that feeds every random operand.
  function automatic void step();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
  endfunction

  function automatic logic [31:0] status(input logic halted);
    return {26'h0, halted, m_to, m_pd, m_z, m_dc, m_c};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Offers one instruction with random operands and notes what must follow.
  task automatic issue(input exec_pkg::op_type op, input logic [7:0] lit);
    logic [7:0]  fd, a, res;
    logic [8:0]  d;
    logic [6:0]  fa;
    logic [12:0] st;
    logic        dst, wen, pcl, hlt, arith;
    step();
    fd = rnd[7:0];
    fa = rnd[14:8];
    dst = rnd[15];
    st = rnd[28:16];
    issue_valid <= 1'b1;
    issue_op <= op;
    issue_literal <= lit;
    issue_file_data <= fd;
    issue_file_addr <= fa;
    issue_dest <= dst;
    stack_top <= st;
    do @(negedge clk); while (issue_ready !== 1'b1);
    @(posedge clk);
    retired++;
    {wen, pcl, hlt, arith} = 4'h0;
    res = m_acc;
    case (op)
      exec_pkg::halt_op: begin
        hlt = 1'b1;
        m_to = 1'b1;
        m_pd = 1'b0;
      end
      exec_pkg::return_op: pcl = 1'b1;
      exec_pkg::rotate_right_carry_op: begin
        res = {m_c, fd[7:1]};
        m_c = fd[0];
        wen = dst;
        arith = 1'b1;
      end
      exec_pkg::literal_minus_acc_op, exec_pkg::file_minus_acc_op: begin
        a = (op == exec_pkg::literal_minus_acc_op) ? lit : fd;
        d = {1'b0, a} - {1'b0, m_acc};
        res = d[7:0];
        m_c = ~d[8];
        m_dc = a[3:0] >= m_acc[3:0];
        m_z = res == 8'h00;
        wen = (op == exec_pkg::file_minus_acc_op) && dst;
        arith = 1'b1;
      end
      default: ;
    endcase
    if (arith && !wen) begin
      m_acc = res;
    end
    exp_q.push_back({m_acc, m_c, m_dc, m_z, wen, wen ? fa : 7'h00, wen ? res : 8'h00, pcl, pcl,
      pcl ? st : 13'h0000, pcl, hlt, hlt, m_to, m_pd, hlt, ~(pcl | hlt)});
  endtask

  // Bus write: address and data offered together, each released when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic a1, w1, ad, wd;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aq.push_back({r, 32'h0});
    {ad, wd} = 2'b00;
    while (!(ad && wd)) begin
      @(negedge clk);
      a1 = awvalid && awready === 1'b1;
      w1 = wvalid && wready === 1'b1;
      @(posedge clk);
      if (a1) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (w1) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    aq.push_back({r, d});
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    @(posedge clk);
    rready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watches the outputs and takes the oldest note whenever a result is due.
  always @(posedge clk) begin
    if (pend) begin
      samples_checked++;
      if (exp_q.size() == 0 || snap !== exp_q[0]) fail("issue result");
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    pend = (issue_valid && issue_ready && reset_n) === 1'b1;
    if ((bvalid && bready) === 1'b1 || (rvalid && rready) === 1'b1) begin
      samples_checked++;
      if (aq.size() == 0 || (bvalid ? {bresp, 32'h0} : {rresp, rdata}) !== aq[0]) begin
        fail("bus answer");
      end
      if (aq.size() != 0) void'(aq.pop_front());
    end
  end

  // Cuts a hang short; the whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {clk, reset_n, issue_valid, issue_dest, awvalid, wvalid, bready, arvalid, rready} = 9'h0;
    {issue_file_addr, issue_literal, issue_file_data, awaddr, araddr, wstrb} = 43'h0;
    {wdata, stack_top, pend, num_errors, samples_checked, retired, cycles} = 174'h0;
    issue_op = exec_pkg::no_op;
    {m_c, m_dc, m_z, m_acc, m_pd, m_to} = 13'h0003;
    rnd = 32'h2def;
    ops = '{exec_pkg::rotate_right_carry_op, exec_pkg::literal_minus_acc_op,
            exec_pkg::file_minus_acc_op, exec_pkg::no_op};
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    axi_rd(exec_pkg::STATUS_OFFSET, status(1'b0), exec_pkg::RESP_OKAY);
    axi_rd(8'h10, 32'h0, exec_pkg::RESP_SLVERR);
    axi_wr(8'h10, 32'hffff_ffff, exec_pkg::RESP_SLVERR);
    axi_wr(exec_pkg::ACC_OFFSET, 32'h0000_00aa, exec_pkg::RESP_OKAY);
    @(posedge clk);
    issue(exec_pkg::literal_minus_acc_op, 8'h00);
    issue(exec_pkg::literal_minus_acc_op, 8'h01);
    repeat (80) begin
      step();
      issue(ops[rnd[1:0]], rnd[23:16]);
    end
    issue(exec_pkg::return_op, 8'h00);
    issue(exec_pkg::file_minus_acc_op, 8'h00);
    issue_valid <= 1'b0;
    axi_rd(exec_pkg::ACC_OFFSET, {24'h0, m_acc}, exec_pkg::RESP_OKAY);
    axi_rd(exec_pkg::STATUS_OFFSET, status(1'b0), exec_pkg::RESP_OKAY);
    axi_wr(exec_pkg::CTRL_OFFSET, 32'h0, exec_pkg::RESP_OKAY);
    @(negedge clk);
    samples_checked++;
    if (issue_ready !== 1'b0) fail("issue accepted while disabled");
    axi_wr(exec_pkg::CTRL_OFFSET, 32'h1, exec_pkg::RESP_OKAY);
    @(posedge clk);
    issue(exec_pkg::halt_op, 8'h00);
    issue_valid <= 1'b0;
    repeat (6) @(negedge clk);
    samples_checked++;
    if ({osc_stop, issue_ready} !== 2'b10) fail("halt not held");
    axi_rd(exec_pkg::STATUS_OFFSET, status(1'b1), exec_pkg::RESP_OKAY);
    axi_wr(exec_pkg::CTRL_OFFSET, 32'h3, exec_pkg::RESP_OKAY);
    @(posedge clk);
    issue(exec_pkg::rotate_right_carry_op, 8'h00);
    issue_valid <= 1'b0;
    axi_rd(exec_pkg::RETIRED_OFFSET, retired, exec_pkg::RESP_OKAY);
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule

`default_nettype wire
